/* File: rtl/cpg_top.sv */
// command pulse decoder, smoothing filter and electronic gear of the position front end
`timescale 1ns/100ps
`include "cpg_cfg.svh"

module cpg_top import cpg_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire cpg_bus_t i_bus,
  output logic [31:0] o_rdata,
  input wire logic i_step_pulse_line,
  input wire logic i_direction_line,
  input wire logic i_gear_select_low,
  input wire logic i_gear_select_high,
  output logic signed [17:0] o_pos_delta,
  output logic signed [31:0] o_pos_cmd,
  output logic [29:0] o_resolution
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // zero is not a legal gear or factor value, so it is taken as one
  function automatic logic [14:0] nonzero15(input logic [31:0] w);
    nonzero15 = (w[14:0] == 15'h0000) ? 15'h0001 : w[14:0];
  endfunction

  // floor division of remainder plus signed numerator by the denominator
  function automatic logic signed [35:0] gear_step(input logic signed [17:0] rem, input logic signed [1:0] dir,
                                                  input logic [14:0] num, input logic [14:0] den);
    logic signed [17:0] x;
    logic signed [17:0] q;
    logic signed [17:0] d;
    x = '0;
    q = '0;
    d = $signed({3'h0, den});
    if (dir > 0) begin
      x = rem + $signed({3'h0, num});
    end else begin
      x = rem - $signed({3'h0, num});
    end
    if (x >= 0) begin
      q = x / d;
    end else begin
      q = -((-x + d - 18'sh00001) / d);
    end
    gear_step = {q, 18'(x - q * d)};
  endfunction

  // quadrature step: A leading B counts up
  function automatic logic signed [1:0] quad_step(input logic [1:0] prv, input logic [1:0] cur);
    case ({prv[0], prv[1], cur[0], cur[1]})
      4'h2, 4'hB, 4'hD, 4'h4: quad_step = 2'sb01;
      4'h1, 4'h7, 4'hE, 4'h8: quad_step = -2'sb01;
      default: quad_step = 2'sb00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state and combinational terms

  cpg_state_t st_q;
  cpg_state_t st_d;
  logic [1:0] filt;
  logic [1:0] lines;
  logic signed [1:0] raw_evt;
  logic signed [1:0] evt;
  logic signed [1:0] smooth_out;
  logic [31:0] smooth_thr;
  logic [14:0] act_num;
  logic signed [35:0] gstep;
  logic [23:0] backlog_mag;
  logic [31:0] acc_sum;

  cpg_line_filter cpg_line_filter_inst (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_lines(st_q.line_s2),
    .i_level(st_q.cfg.flt_level),
    .i_dir_bypass(st_q.cfg.dir_flt_off),
    .o_lines(filt)
  );

  // each line can be inverted: a counted edge moves to the falling one, an inverted direction level reverses the count
  assign lines = filt ^ st_q.cfg.line_logic;

  // the active numerator follows the synchronised select pins every cycle
  always_comb begin
    case (st_q.gear_s2)
      2'b00: act_num = st_q.cfg.num_first;
      2'b01: act_num = st_q.cfg.num_second;
      2'b10: act_num = st_q.cfg.num_third;
      default: act_num = st_q.cfg.num_fourth;
    endcase
  end

  // pulse decoder
  always_comb begin
    raw_evt = 2'sb00;
    case (cpg_fmt_t'(st_q.cfg.format))
      CPG_FMT_STEP_DIR: begin
        if (lines[0] && !st_q.prev[0]) begin
          raw_evt = lines[1] ? 2'sb01 : -2'sb01;
        end
      end
      CPG_FMT_FWD_REV: begin
        if (lines[0] && !st_q.prev[0] && !(lines[1] && !st_q.prev[1])) begin
          raw_evt = 2'sb01;
        end else if (lines[1] && !st_q.prev[1] && !(lines[0] && !st_q.prev[0])) begin
          raw_evt = -2'sb01;
        end
      end
      CPG_FMT_QUAD: begin
        raw_evt = quad_step(st_q.prev, lines);
      end
      default: raw_evt = 2'sb00;
    endcase
    evt = st_q.cfg.dir_inv ? -raw_evt : raw_evt;
  end

  // smoothing: one pulse leaves each time the running sum of the backlog passes
  // setting times cycles per ms, so the rate is backlog over the time constant
  assign smooth_thr = 32'(st_q.cfg.smooth) * 32'(`CPG_CYC_PER_UNIT);
  assign backlog_mag = st_q.backlog[23] ? 24'(-st_q.backlog) : 24'(st_q.backlog);
  assign acc_sum = st_q.acc + 32'(backlog_mag);

  always_comb begin
    smooth_out = 2'sb00;
    if (st_q.backlog == 24'sh000000) begin
      if (st_q.cfg.smooth == 10'h000) begin
        smooth_out = evt;
      end
    end else if (st_q.cfg.smooth == 10'h000 || acc_sum >= smooth_thr) begin
      // a leftover backlog drains at one pulse per cycle even after bypass is chosen
      smooth_out = st_q.backlog[23] ? -2'sb01 : 2'sb01;
    end
  end

  assign gstep = gear_step(st_q.rem, smooth_out, act_num, st_q.cfg.denom);

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_d = st_q;
    // two flops on every pin before use
    st_d.line_s1 = {i_direction_line, i_step_pulse_line};
    st_d.line_s2 = st_q.line_s1;
    st_d.gear_s1 = {i_gear_select_high, i_gear_select_low};
    st_d.gear_s2 = st_q.gear_s1;
    st_d.prev = lines;
    // conservation of pulses through the smoothing stage
    st_d.backlog = st_q.backlog + 24'(evt) - 24'(smooth_out);
    if (st_q.backlog == 24'sh000000 || st_q.cfg.smooth == 10'h000) begin
      st_d.acc = 32'h0000_0000;
    end else if (acc_sum >= smooth_thr) begin
      st_d.acc = acc_sum - smooth_thr;
    end else begin
      st_d.acc = acc_sum;
    end
    // gear: the remainder stays in denominator units, so numerator swaps keep it
    if (smooth_out != 2'sb00) begin
      st_d.delta = gstep[35:18];
      st_d.rem = gstep[17:0];
      // a part-select is unsigned, so the step is made signed before it is widened
      st_d.pos = st_q.pos + 32'($signed(gstep[35:18]));
    end else begin
      st_d.delta = 18'sh00000;
    end
    // register writes
    if (i_bus.wr) begin
      if (i_bus.addr == `CPG_OFS_ENC_ONE) begin
        st_d.cfg.enc_one = nonzero15(i_bus.wdata);
      end else if (i_bus.addr == `CPG_OFS_ENC_TWO) begin
        st_d.cfg.enc_two = nonzero15(i_bus.wdata);
      end else if (i_bus.addr == `CPG_OFS_NUM_FIRST) begin
        st_d.cfg.num_first = nonzero15(i_bus.wdata);
      end else if (i_bus.addr == `CPG_OFS_DENOM) begin
        st_d.cfg.denom = nonzero15(i_bus.wdata);
        st_d.rem = 18'sh00000; // old remainder has no meaning in the new unit
      end else if (i_bus.addr == `CPG_OFS_NUM_SECOND) begin
        st_d.cfg.num_second = nonzero15(i_bus.wdata);
      end else if (i_bus.addr == `CPG_OFS_NUM_THIRD) begin
        st_d.cfg.num_third = nonzero15(i_bus.wdata);
      end else if (i_bus.addr == `CPG_OFS_NUM_FOURTH) begin
        st_d.cfg.num_fourth = nonzero15(i_bus.wdata);
      end else if (i_bus.addr == `CPG_OFS_FORMAT) begin
        st_d.cfg.format = (i_bus.wdata[1:0] > `CPG_MAX_FORMAT) ? `CPG_MAX_FORMAT : i_bus.wdata[1:0];
      end else if (i_bus.addr == `CPG_OFS_DIR_INV) begin
        st_d.cfg.dir_inv = i_bus.wdata[0];
      end else if (i_bus.addr == `CPG_OFS_LINE_LOGIC) begin
        st_d.cfg.line_logic = i_bus.wdata[1:0];
      end else if (i_bus.addr == `CPG_OFS_FLT_LEVEL) begin
        st_d.cfg.flt_level = (i_bus.wdata[31:5] != '0 || i_bus.wdata[4:0] > `CPG_MAX_FLT_LEVEL) ?
                             `CPG_MAX_FLT_LEVEL : i_bus.wdata[4:0];
      end else if (i_bus.addr == `CPG_OFS_DIR_FLT) begin
        st_d.cfg.dir_flt_off = i_bus.wdata[0];
      end else if (i_bus.addr == `CPG_OFS_SMOOTH) begin
        st_d.cfg.smooth = (i_bus.wdata[31:10] != '0 || i_bus.wdata[9:0] > `CPG_MAX_SMOOTH) ?
                          `CPG_MAX_SMOOTH : i_bus.wdata[9:0];
      end
    end
    // register reads, answered in the next cycle only
    st_d.rdata = 32'h0000_0000;
    if (i_bus.rd) begin
      if (i_bus.addr == `CPG_OFS_ENC_ONE) begin
        st_d.rdata = 32'(st_q.cfg.enc_one);
      end else if (i_bus.addr == `CPG_OFS_ENC_TWO) begin
        st_d.rdata = 32'(st_q.cfg.enc_two);
      end else if (i_bus.addr == `CPG_OFS_NUM_FIRST) begin
        st_d.rdata = 32'(st_q.cfg.num_first);
      end else if (i_bus.addr == `CPG_OFS_DENOM) begin
        st_d.rdata = 32'(st_q.cfg.denom);
      end else if (i_bus.addr == `CPG_OFS_NUM_SECOND) begin
        st_d.rdata = 32'(st_q.cfg.num_second);
      end else if (i_bus.addr == `CPG_OFS_NUM_THIRD) begin
        st_d.rdata = 32'(st_q.cfg.num_third);
      end else if (i_bus.addr == `CPG_OFS_NUM_FOURTH) begin
        st_d.rdata = 32'(st_q.cfg.num_fourth);
      end else if (i_bus.addr == `CPG_OFS_FORMAT) begin
        st_d.rdata = 32'(st_q.cfg.format);
      end else if (i_bus.addr == `CPG_OFS_DIR_INV) begin
        st_d.rdata = 32'(st_q.cfg.dir_inv);
      end else if (i_bus.addr == `CPG_OFS_LINE_LOGIC) begin
        st_d.rdata = 32'(st_q.cfg.line_logic);
      end else if (i_bus.addr == `CPG_OFS_FLT_LEVEL) begin
        st_d.rdata = 32'(st_q.cfg.flt_level);
      end else if (i_bus.addr == `CPG_OFS_DIR_FLT) begin
        st_d.rdata = 32'(st_q.cfg.dir_flt_off);
      end else if (i_bus.addr == `CPG_OFS_SMOOTH) begin
        st_d.rdata = 32'(st_q.cfg.smooth);
      end else if (i_bus.addr == `CPG_OFS_POSITION) begin
        st_d.rdata = st_q.pos;
      end else if (i_bus.addr == `CPG_OFS_BACKLOG) begin
        st_d.rdata = 32'(st_q.backlog);
      end else if (i_bus.addr == `CPG_OFS_RESOLUTION) begin
        st_d.rdata = 32'(o_resolution);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers and outputs

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= '0;
      st_q.cfg.enc_one <= `CPG_RST_ENC_ONE;
      st_q.cfg.enc_two <= `CPG_RST_ENC_TWO;
      st_q.cfg.num_first <= `CPG_RST_GEAR;
      st_q.cfg.denom <= `CPG_RST_GEAR;
      st_q.cfg.num_second <= `CPG_RST_GEAR;
      st_q.cfg.num_third <= `CPG_RST_GEAR;
      st_q.cfg.num_fourth <= `CPG_RST_GEAR;
      st_q.cfg.format <= `CPG_RST_FORMAT;
      st_q.cfg.line_logic <= `CPG_RST_LINE_LOGIC;
      st_q.cfg.flt_level <= `CPG_RST_FLT_LEVEL;
      st_q.cfg.smooth <= `CPG_RST_SMOOTH;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_rdata = st_q.rdata;
  assign o_pos_delta = st_q.delta;
  assign o_pos_cmd = st_q.pos;
  // resolution is informational; software keeps the product within range
  assign o_resolution = 30'(st_q.cfg.enc_one) * 30'(st_q.cfg.enc_two);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic signed [31:0] chk_in_q;
  logic signed [31:0] chk_out_q;

  // running totals seen only by the checks below
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      chk_in_q <= 32'sh0;
      chk_out_q <= 32'sh0;
    end else begin
      chk_in_q <= chk_in_q + 32'(evt);
      chk_out_q <= chk_out_q + 32'(smooth_out);
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  property p_format_legal;
    st_q.cfg.format <= `CPG_MAX_FORMAT;
  endproperty
  a_format_legal: assert property (p_format_legal) else $error("format setting out of range");

  property p_dir_invert;
    (raw_evt != 2'sb00 && st_q.cfg.dir_inv) |-> evt == -raw_evt;
  endproperty
  a_dir_invert: assert property (p_dir_invert) else $error("count direction not reversed");

  property p_no_pulse_lost;
    chk_in_q - chk_out_q == 32'(st_q.backlog);
  endproperty
  a_no_pulse_lost: assert property (p_no_pulse_lost) else $error("smoothing lost or made a pulse");

  property p_bypass;
    (st_q.cfg.smooth == 10'h000 && st_q.backlog == 24'sh000000) |-> smooth_out == evt ##1 st_q.backlog == 24'sh0;
  endproperty
  a_bypass: assert property (p_bypass) else $error("zero setting did not bypass");

  property p_smooth_idle;
    (st_q.cfg.smooth != 10'h000 && st_q.backlog == 24'sh000000) |-> smooth_out == 2'sb00;
  endproperty
  a_smooth_idle: assert property (p_smooth_idle) else $error("smoothing emitted with empty backlog");

  property p_rem_range;
    (st_q.rem >= 0) && (st_q.rem < $signed({3'h0, st_q.cfg.denom}));
  endproperty
  a_rem_range: assert property (p_rem_range) else $error("gear remainder out of range");

  property p_gear_select;
    (st_q.gear_s2 == 2'b11) |-> act_num == st_q.cfg.num_fourth;
  endproperty
  a_gear_select: assert property (p_gear_select) else $error("fourth numerator not selected");

  property p_denom_nonzero;
    i_bus.wr && i_bus.addr == `CPG_OFS_DENOM |=> st_q.cfg.denom != 15'h0000;
  endproperty
  a_denom_nonzero: assert property (p_denom_nonzero) else $error("denominator became zero");

  property p_pos_follows;
    (smooth_out != 2'sb00) |=> o_pos_cmd == $past(o_pos_cmd) + 32'(o_pos_delta);
  endproperty
  a_pos_follows: assert property (p_pos_follows) else $error("position did not add gear step");

endmodule

/* File: rtl/cpg_cfg.svh */
// constants of the command pulse gear front end: offsets, reset values, setting limits, timing
`ifndef CPG_CFG_SVH
`define CPG_CFG_SVH

// register byte offsets
`define CPG_OFS_ENC_ONE 8'h00
`define CPG_OFS_ENC_TWO 8'h04
`define CPG_OFS_NUM_FIRST 8'h08
`define CPG_OFS_DENOM 8'h0C
`define CPG_OFS_NUM_SECOND 8'h10
`define CPG_OFS_NUM_THIRD 8'h14
`define CPG_OFS_NUM_FOURTH 8'h18
`define CPG_OFS_FORMAT 8'h1C
`define CPG_OFS_DIR_INV 8'h20
`define CPG_OFS_LINE_LOGIC 8'h24
`define CPG_OFS_FLT_LEVEL 8'h28
`define CPG_OFS_DIR_FLT 8'h2C
`define CPG_OFS_SMOOTH 8'h30
`define CPG_OFS_POSITION 8'h34
`define CPG_OFS_BACKLOG 8'h38
`define CPG_OFS_RESOLUTION 8'h3C

// reset values
`define CPG_RST_ENC_ONE 15'h2710
`define CPG_RST_ENC_TWO 15'h0001
`define CPG_RST_GEAR 15'h0001
`define CPG_RST_FORMAT 2'h0
`define CPG_RST_LINE_LOGIC 2'h0
`define CPG_RST_FLT_LEVEL 5'h00
`define CPG_RST_SMOOTH 10'h000

// setting limits
`define CPG_MAX_FORMAT 2'h2
`define CPG_MAX_FLT_LEVEL 5'h15
`define CPG_MAX_SMOOTH 10'h3E8

// timing: clock rate, smoothing unit, filter base and step
`define CPG_CLK_MHZ 10
`define CPG_SMOOTH_UNIT_US 1000
`define CPG_CYC_PER_UNIT (`CPG_CLK_MHZ * `CPG_SMOOTH_UNIT_US)
`define CPG_FLT_BASE_NS 200
`define CPG_FLT_STEP_NS 400
`define CPG_FLT_BASE_CYC ((`CPG_FLT_BASE_NS * `CPG_CLK_MHZ + 999) / 1000)
`define CPG_FLT_STEP_CYC ((`CPG_FLT_STEP_NS * `CPG_CLK_MHZ + 999) / 1000)

`endif

/* File: rtl/cpg_pkg.sv */
// types shared by the command pulse gear front end
package cpg_pkg;

  typedef enum logic [1:0] {
    CPG_FMT_STEP_DIR,
    CPG_FMT_FWD_REV,
    CPG_FMT_QUAD
  } cpg_fmt_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } cpg_bus_t;

  typedef struct packed {
    logic [14:0] enc_one;
    logic [14:0] enc_two;
    logic [14:0] num_first;
    logic [14:0] denom;
    logic [14:0] num_second;
    logic [14:0] num_third;
    logic [14:0] num_fourth;
    logic [1:0] format;
    logic dir_inv;
    logic [1:0] line_logic;
    logic [4:0] flt_level;
    logic dir_flt_off;
    logic [9:0] smooth;
  } cpg_cfg_t;

  typedef struct packed {
    logic [1:0] line_s1;
    logic [1:0] line_s2;
    logic [1:0] gear_s1;
    logic [1:0] gear_s2;
    logic [1:0] prev;
    cpg_cfg_t cfg;
    logic signed [23:0] backlog;
    logic [31:0] acc;
    logic signed [17:0] rem;
    logic signed [17:0] delta;
    logic signed [31:0] pos;
    logic [31:0] rdata;
  } cpg_state_t;

  typedef struct packed {
    logic [7:0] cnt_step;
    logic [7:0] cnt_dir;
    logic [1:0] out;
  } cpg_flt_state_t;

endpackage

/* File: rtl/cpg_line_filter.sv */
// digital noise filter for the step and direction lines
`timescale 1ns/100ps
`include "cpg_cfg.svh"

module cpg_line_filter import cpg_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [1:0] i_lines,
  input wire logic [4:0] i_level,
  input wire logic i_dir_bypass,
  output logic [1:0] o_lines
);

  cpg_flt_state_t st_q;
  cpg_flt_state_t st_d;
  logic [7:0] thr;

  // hold time grows linearly with the level, so the accepted rate falls as it rises
  function automatic logic [7:0] hold_cycles(input logic [4:0] lvl);
    hold_cycles = 8'(`CPG_FLT_BASE_CYC) + 8'(lvl) * 8'(`CPG_FLT_STEP_CYC);
  endfunction

  assign thr = hold_cycles(i_level);

  // the step line, and the direction line unless bypassed, change only after the new level held for thr samples
  always_comb begin
    st_d = st_q;
    if (i_lines[0] == st_q.out[0]) begin
      st_d.cnt_step = 8'h00;
    end else if (st_q.cnt_step + 8'h01 >= thr) begin
      st_d.cnt_step = 8'h00;
      st_d.out[0] = i_lines[0];
    end else begin
      st_d.cnt_step = st_q.cnt_step + 8'h01;
    end
    if (i_dir_bypass) begin
      st_d.cnt_dir = 8'h00;
      st_d.out[1] = i_lines[1];
    end else if (i_lines[1] == st_q.out[1]) begin
      st_d.cnt_dir = 8'h00;
    end else if (st_q.cnt_dir + 8'h01 >= thr) begin
      st_d.cnt_dir = 8'h00;
      st_d.out[1] = i_lines[1];
    end else begin
      st_d.cnt_dir = st_q.cnt_dir + 8'h01;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_lines = st_q.out;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  property p_step_needs_hold;
    $changed(o_lines[0]) |-> ($past(i_lines[0], 1) == o_lines[0]) && ($past(i_lines[0], 2) == o_lines[0]);
  endproperty
  a_step_needs_hold: assert property (p_step_needs_hold) else $error("step line passed a glitch");

  property p_dir_bypass;
    i_dir_bypass |=> o_lines[1] == $past(i_lines[1]);
  endproperty
  a_dir_bypass: assert property (p_dir_bypass) else $error("direction line not bypassed");

endmodule

/* File: bench/cpg_host_model.sv */
// host motion controller model driving the step and direction lines
`timescale 1ns/100ps

module cpg_host_model (
  input wire logic i_mclk,
  input wire logic i_go,
  input wire logic [1:0] i_fmt,
  input wire logic i_neg,
  input wire logic i_lag,
  input wire logic [7:0] i_width,
  output logic o_step,
  output logic o_dir,
  output logic o_busy
);
  initial begin
    o_step = 1'b0;
    o_dir = 1'b0;
    o_busy = 1'b0;
  end

  // one command unit per go, four in quadrature; lines move just after an edge, push-pull so they hold
  always @(posedge i_mclk) begin
    if (i_go) begin
      o_busy <= 1'b1;
      if (i_fmt == 2'h2) begin // leading line decides the sign
        if (i_neg) o_dir <= 1'b1; else o_step <= 1'b1;
        repeat (i_width) @(posedge i_mclk);
        if (i_neg) o_step <= 1'b1; else o_dir <= 1'b1;
        repeat (i_width) @(posedge i_mclk);
        if (i_neg) o_dir <= 1'b0; else o_step <= 1'b0;
        repeat (i_width) @(posedge i_mclk);
        if (i_neg) o_step <= 1'b0; else o_dir <= 1'b0;
      end else if (i_fmt == 2'h1) begin // forward and reverse lines
        if (i_neg) o_dir <= 1'b1; else o_step <= 1'b1;
        repeat (i_width) @(posedge i_mclk);
        o_dir <= 1'b0;
        o_step <= 1'b0;
      end else begin // direction level, late only when a lag is asked
        if (!i_lag) o_dir <= !i_neg;
        repeat (5) @(posedge i_mclk);
        o_step <= 1'b1;
        repeat (10) @(posedge i_mclk);
        o_dir <= !i_neg;
        repeat (i_width - 10) @(posedge i_mclk);
        o_step <= 1'b0;
      end
      repeat (i_width) @(posedge i_mclk);
      o_busy <= 1'b0;
    end
  end
endmodule

/* File: bench/command_pulse_gear_input_test.sv */
// self-checking bench of the command pulse gear front end
`timescale 1ns/100ps

module command_pulse_gear_input_test;
  import cpg_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  cpg_bus_t bus;
  logic gsl, gsh, h_go, h_neg, h_lag, step, dir, busy;
  logic [1:0] h_fmt;
  logic [7:0] h_w;
  logic [31:0] rdata;
  logic signed [17:0] pdelta;
  logic signed [31:0] pcmd, last_cmd;
  logic [29:0] res;
  logic [31:0] seed = 32'h81C0;
  logic [31:0] dv[17] = '{32'h2710, 32'h1, 32'h1, 32'h1, 32'h1, 32'h1, 32'h1, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h2710, 32'h0};
  logic [7:0] na[4] = '{8'h08, 8'h10, 8'h14, 8'h18};
  int bad_count = 0;
  int num_checks = 0;
  int q[$];
  logic [31:0] rq[$];
  bit mute = 0;
  bit rd_seen = 0;
  int gn = 1;
  int gm = 1;
  int rem = 0;
  int i, j, k;

  always #50 i_mclk = ~i_mclk;

  cpg_top cpg_top_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_bus(bus), .o_rdata(rdata),
    .i_step_pulse_line(step), .i_direction_line(dir), .i_gear_select_low(gsl),
    .i_gear_select_high(gsh), .o_pos_delta(pdelta), .o_pos_cmd(pcmd), .o_resolution(res));

  cpg_host_model cpg_host_model_inst (.i_mclk(i_mclk), .i_go(h_go), .i_fmt(h_fmt), .i_neg(h_neg),
    .i_lag(h_lag), .i_width(h_w), .o_step(step), .o_dir(dir), .o_busy(busy));

  ////////////////////////////////////////
  task chk(input bit ok, input string m);
    num_checks++;
    if (!ok) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // bus cycles leave one idle edge so a strobe is never set and cleared at once
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge i_mclk) bus <= '0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    @(posedge i_mclk) bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge i_mclk) bus <= '0;
  endtask

  // floor division keeps the carried remainder in 0..M-1, so no position is lost
  task expect_units(input int sgn, input int units);
    int x, qv;
    for (int u = 0; u < units; u++) begin
      x = rem + sgn * gn;
      qv = x / gm;
      if (x - qv * gm < 0) qv = qv - 1;
      rem = x - qv * gm;
      if (qv != 0) q.push_back(qv);
    end
  endtask

  task burst(input int cnt, input bit neg, input bit lag, input logic [7:0] w, input int sgn, input bit fast);
    for (int p = 0; p < cnt; p++) begin
      expect_units(sgn, h_fmt == 2'h2 ? 4 : 1);
      @(posedge i_mclk);
      h_neg <= neg;
      h_lag <= lag;
      h_w <= w;
      h_go <= 1'b1;
      @(posedge i_mclk);
      h_go <= 1'b0;
      k = 0;
      do begin
        @(posedge i_mclk);
        k++;
      end while ((busy || k < 2) && k < 2000);
      if (k >= 2000) begin
        chk(0, "host hang");
        stop_test;
      end
    end
    repeat (20) @(posedge i_mclk);
    if (fast) chk(q.size() == 0, "result late");
  endtask

  ////////////////////////////////////////
  // watcher: read data one cycle after the strobe, steps against the oldest note
  always @(negedge i_mclk) begin
    if (rd_seen) begin
      if (rq.size() == 0) chk(0, "unexpected read");
      else chk(rdata === rq.pop_front(), "read data");
    end
    rd_seen = bus.rd;
    if (pdelta !== 18'h0 && !mute) begin
      chk(q.size() != 0, "unexpected step");
      if (q.size() != 0) chk(pdelta === 18'(q.pop_front()), "step value");
      chk(pcmd === last_cmd + 32'(pdelta), "position sum");
    end
    last_cmd = pcmd;
  end

  ////////////////////////////////////////
  initial begin
    bus = '0;
    {gsl, gsh, h_go, h_neg, h_lag} = 5'h0;
    h_fmt = 2'h0;
    h_w = 8'h0C;
    last_cmd = 32'sh0;
    repeat (16) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    // reset map, the last word unmapped
    for (i = 0; i < 17; i++) rd(8'(i * 4), dv[i]);
    chk(res === 30'h2710, "resolution reset");
    // out-of-range settings are clamped
    wr(8'h1C, 32'h3);
    rd(8'h1C, 32'h2);
    wr(8'h28, 32'h1F);
    rd(8'h28, 32'h15);
    wr(8'h30, 32'h7D0);
    rd(8'h30, 32'h3E8);
    wr(8'h0C, 32'h0);
    rd(8'h0C, 32'h1);
    wr(8'h00, 32'h12C);
    wr(8'h04, 32'h190); // product kept at 120000
    rd(8'h3C, 32'h1D4C0);
    chk(res === 30'h1D4C0, "resolution");
    wr(8'h00, 32'h2710);
    wr(8'h04, 32'h1);
    wr(8'h28, 32'h0);
    wr(8'h30, 32'h0);
    // every format, both senses, both count directions
    for (i = 0; i < 3; i++) begin
      wr(8'h1C, 32'(i));
      h_fmt <= 2'(i);
      for (j = 0; j < 4; j++) begin
        wr(8'h20, 32'(j[1]));
        burst(2, j[0], 0, 8'h0C, (j[0] ? -1 : 1) * (j[1] ? -1 : 1), 1);
      end
    end
    // line logic; the setting change itself may count once, so it is muted
    wr(8'h1C, 32'h0);
    wr(8'h20, 32'h0);
    h_fmt <= 2'h0;
    for (i = 1; i < 5; i++) begin
      mute = 1;
      wr(8'h24, 32'(i % 4));
      repeat (30) @(posedge i_mclk);
      mute = 0;
      burst(2, 0, 0, 8'h0C, (i % 4) > 1 ? -1 : 1, 1);
    end
    // live numerator selection with a carried remainder
    wr(8'h0C, 32'h4); // ratios stay inside 1/50..200
    gm = 4;
    rem = 0;
    for (i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      gn = seed % 799 + 1;
      wr(na[i], 32'(gn));
      gsl <= i[0];
      gsh <= i[1];
      repeat (8) @(posedge i_mclk);
      burst(3, i[0], 0, 8'h0C, i[0] ? -1 : 1, 1);
    end
    gsl <= 1'b0;
    gsh <= 1'b0;
    wr(8'h08, 32'h1);
    wr(8'h0C, 32'h1);
    gn = 1;
    gm = 1;
    rem = 0;
    // longest filter: short pulses vanish, late direction seen only when bypassed
    wr(8'h28, 32'h15);
    burst(2, 0, 0, 8'h0C, 0, 1);
    burst(1, 0, 0, 8'h64, 1, 1);
    burst(1, 1, 1, 8'h64, 1, 1);
    wr(8'h2C, 32'h1);
    burst(1, 0, 1, 8'h64, 1, 1);
    wr(8'h28, 32'h0);
    wr(8'h2C, 32'h0);
    // smoothing of 1 ms delays but keeps every pulse
    wr(8'h30, 32'h1);
    burst(5, 0, 0, 8'h0C, 1, 0);
    chk(q.size() == 5, "not delayed");
    rd(8'h38, 32'h5);
    for (k = 0; k < 40000 && q.size() != 0; k++) @(posedge i_mclk);
    chk(q.size() == 0, "pulses lost");
    if (q.size() != 0) stop_test;
    rd(8'h38, 32'h0);
    wr(8'h30, 32'h0);
    burst(1, 0, 0, 8'h0C, 1, 1);
    stop_test;
  end
endmodule
